// ---- hw/pll_cfg_pkg.sv ----
// Package: register map, field positions and counts of the synthesizer config bank
package pcr_pkg;
	localparam logic [7:0] ADDR_LD_BLEED_VCO = 8'h27;
	localparam logic [7:0] ADDR_LOCK_COUNT_SELECT     = 8'h28;
	localparam logic [7:0] ADDR_POL_SYNC     = 8'h2a;
	localparam logic [7:0] ADDR_MOD_CTRL     = 8'h2b;
	localparam logic [7:0] ADDR_INT_DIVIDER  = 8'h10;
	localparam logic [7:0] RESET_VALUE       = 8'h00;
	// Field positions
	localparam int POS_GATED_BLEED = 4;
	localparam int POS_BLEED_EN    = 3;
	localparam int POS_OSC_PD      = 2;
	localparam int POS_PBS_LO      = 0;
	localparam int POS_COUNT_LO    = 1;
	localparam int POS_LOSS_EN     = 0;
	localparam int POS_POLARITY    = 5;
	localparam int POS_CS_SYNC     = 3;
	localparam int POS_HALF_LSB    = 5;
	localparam int POS_AUX_MOD     = 4;
	localparam int POS_MASK_RST    = 2;
	localparam int POS_MOD_PD      = 0;
	// Lock counts in comparison cycles
	localparam logic [13:0] COUNT_1024 = 14'h03ff;
	localparam logic [13:0] COUNT_2048 = 14'h07ff;
	localparam logic [13:0] COUNT_4096 = 14'h0fff;
	localparam logic [13:0] COUNT_8192 = 14'h1fff;
	// Reference considered stopped after this many system clocks without an edge
	localparam logic [7:0] REF_STALL_CYCLES = 8'h40;
	// Prescaler bias codes
	localparam logic [1:0] PBS_PLUS10  = 2'h0;
	localparam logic [1:0] PBS_NOMINAL = 2'h1;
	localparam logic [1:0] PBS_MINUS10 = 2'h2;
	localparam logic [1:0] PBS_MINUS20 = 2'h3;

	typedef struct packed {
		logic       bleed_current_enable;
		logic       gated_bleed_enable;
		logic       bleed_polarity;
		logic       oscillator_power_down;
		logic [1:0] prescaler_bias_select;
		logic       modulator_power_down;
		logic       aux_modulator_enable;
		logic       half_lsb_add;
	} pcr_analog_t;

	typedef enum logic [1:0] {
		PCR_BIAS_PLUS10,
		PCR_BIAS_NOMINAL,
		PCR_BIAS_MINUS10,
		PCR_BIAS_MINUS20
	} pcr_bias_t;
endpackage

// ---- hw/pcr_lock_detect.sv ----
// Digital lock detect counter with loss-of-lock monitoring
`timescale 1ns/1ps
module pcr_lock_detect (
	input  wire logic        i_clock,
	input  wire logic        i_arst_n,
	input  wire logic        i_enable,
	input  wire logic        i_pfd_cycle,
	input  wire logic        i_in_window,
	input  wire logic        i_ref_edge,
	input  wire logic [1:0]  i_count_sel,
	input  wire logic        i_loss_enable,
	output logic             o_locked
);
	logic [13:0] count;
	logic [13:0] target;
	logic [7:0]  stall;
	logic        ref_lost;

	always_comb begin
		case (i_count_sel)
			2'h0:    target = pcr_pkg::COUNT_1024;
			2'h1:    target = pcr_pkg::COUNT_2048;
			2'h2:    target = pcr_pkg::COUNT_4096;
			default: target = pcr_pkg::COUNT_8192;
		endcase
	end

	assign ref_lost = i_loss_enable && (stall == pcr_pkg::REF_STALL_CYCLES);

	// Reference-edge watchdog; only runs when monitoring is on
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stall <= 8'h00;
		end else if (i_enable) begin
			if (i_ref_edge || !i_loss_enable) begin
				stall <= 8'h00;
			end else if (stall != pcr_pkg::REF_STALL_CYCLES) begin
				stall <= stall + 8'h01;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count    <= 14'h0000;
			o_locked <= 1'b0;
		end else if (i_enable) begin
			if (ref_lost) begin
				count    <= 14'h0000;
				o_locked <= 1'b0;
			end else if (i_pfd_cycle) begin
				if (!i_in_window) begin
					count    <= 14'h0000;
					o_locked <= 1'b0;
				end else if (count >= target) begin
					o_locked <= 1'b1;
				end else begin
					count <= count + 14'h0001;
				end
			end
		end
	end

	a_lock_needs_cycle: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		$rose(o_locked) |-> $past(i_pfd_cycle) && $past(i_in_window))
		else $error("lock rose without an in-window cycle");
	a_miss_drops_lock: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_enable && i_pfd_cycle && !i_in_window |=> !o_locked && count == 14'h0000)
		else $error("lock survived an out-of-window cycle");
endmodule

// ---- hw/pcr_config_regs.sv ----
// Synthesizer configuration bank: bleed, prescaler, modulator and lock detect controls
//
// Function
// - Lock rises only after 1024/2048/4096/8192 consecutive in-window comparisons.
// - Loss-of-lock enabled: lock drops when reference stops toggling.
// - Bit 3 of lock-detect register enables bleed current.
// - Two-bit prescaler bias: +10%, nominal, -10%, -20%.
// - Sync register bit 5 chooses bleed polarity, zero negative.
// - Sync register bit 3 aligns chip-select action to reference input.
// - Modulator bit 5 adds half LSB when auxiliary modulator off.
// - Modulator bit 4 enables auxiliary modulator; software matches secondary word.
// - Modulator bit 2 resets mask on integer divider update.
// - Modulator bit 0 powers the modulator down for integer mode.
// - All registers reset to zero; reserved fields written zero; bank stores the full byte, so reserved bits read back as written.
// - Lock-detect register bit 4 enables gated bleed mode.
`timescale 1ns/1ps
module pcr_config_regs (
	input  wire logic                 i_clock,
	input  wire logic                 i_arst_n,
	input  wire logic                 i_clock_en,
	input  wire logic                 i_wr_strobe,
	input  wire logic                 i_rd_strobe,
	input  wire logic [7:0]           i_addr,
	input  wire logic [7:0]           i_wdata,
	input  wire logic                 i_cs_event,
	input  wire logic                 i_ref_in,
	input  wire logic                 i_pfd_cycle,
	input  wire logic                 i_in_window,
	output logic      [7:0]           o_rdata,
	output logic                      o_rvalid,
	output pcr_pkg::pcr_analog_t      o_analog,
	output logic                      o_locked,
	output logic                      o_bleed_active,
	output logic                      o_cs_apply,
	output logic                      o_mask_reset,
	output logic                      o_half_lsb_active
);
	logic [7:0] reg_ld_bleed_vco;
	logic [7:0] reg_lock_count_select;
	logic [7:0] reg_pol_sync;
	logic [7:0] reg_mod_ctrl;
	logic       ref_meta;
	logic       ref_sync;
	logic       ref_prev;
	logic       ref_edge;
	logic       cs_pending;
	logic       locked;
	logic       wr_ok;

	assign wr_ok    = i_clock_en && i_wr_strobe;
	assign ref_edge = ref_sync && !ref_prev;

	////////////////////////////////////////////////////////////////////////////
	// Reference pin synchroniser
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ref_meta <= 1'b0;
			ref_sync <= 1'b0;
			ref_prev <= 1'b0;
		end else if (i_clock_en) begin
			ref_meta <= i_ref_in;
			ref_sync <= ref_meta;
			ref_prev <= ref_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes; full byte stored so reserved bits read back
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			reg_ld_bleed_vco <= pcr_pkg::RESET_VALUE;
			reg_lock_count_select     <= pcr_pkg::RESET_VALUE;
			reg_pol_sync     <= pcr_pkg::RESET_VALUE;
			reg_mod_ctrl     <= pcr_pkg::RESET_VALUE;
		end else if (wr_ok) begin
			case (i_addr)
				pcr_pkg::ADDR_LD_BLEED_VCO: reg_ld_bleed_vco <= i_wdata;
				pcr_pkg::ADDR_LOCK_COUNT_SELECT:     reg_lock_count_select     <= i_wdata;
				pcr_pkg::ADDR_POL_SYNC:     reg_pol_sync     <= i_wdata;
				pcr_pkg::ADDR_MOD_CTRL:     reg_mod_ctrl     <= i_wdata;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Readback; unmapped addresses read zero
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata  <= 8'h00;
			o_rvalid <= 1'b0;
		end else if (i_clock_en) begin
			o_rvalid <= i_rd_strobe;
			if (i_rd_strobe) begin
				case (i_addr)
					pcr_pkg::ADDR_LD_BLEED_VCO: o_rdata <= reg_ld_bleed_vco;
					pcr_pkg::ADDR_LOCK_COUNT_SELECT:     o_rdata <= reg_lock_count_select;
					pcr_pkg::ADDR_POL_SYNC:     o_rdata <= reg_pol_sync;
					pcr_pkg::ADDR_MOD_CTRL:     o_rdata <= reg_mod_ctrl;
					default:                    o_rdata <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog control outputs, registered
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_analog          <= '0;
			o_bleed_active    <= 1'b0;
			o_half_lsb_active <= 1'b0;
		end else if (i_clock_en) begin
			o_analog.bleed_current_enable  <= reg_ld_bleed_vco[pcr_pkg::POS_BLEED_EN];
			o_analog.gated_bleed_enable    <= reg_ld_bleed_vco[pcr_pkg::POS_GATED_BLEED];
			o_analog.oscillator_power_down <= reg_ld_bleed_vco[pcr_pkg::POS_OSC_PD];
			o_analog.prescaler_bias_select <=
				reg_ld_bleed_vco[pcr_pkg::POS_PBS_LO +: 2];
			o_analog.bleed_polarity        <= reg_pol_sync[pcr_pkg::POS_POLARITY];
			o_analog.modulator_power_down  <= reg_mod_ctrl[pcr_pkg::POS_MOD_PD];
			o_analog.aux_modulator_enable  <= reg_mod_ctrl[pcr_pkg::POS_AUX_MOD];
			o_analog.half_lsb_add          <= reg_mod_ctrl[pcr_pkg::POS_HALF_LSB];
			// Gated mode only passes bleed while locked; relies on lock detect being on
			o_bleed_active <= reg_ld_bleed_vco[pcr_pkg::POS_BLEED_EN]
				&& (!reg_ld_bleed_vco[pcr_pkg::POS_GATED_BLEED] || locked);
			o_half_lsb_active <= reg_mod_ctrl[pcr_pkg::POS_HALF_LSB]
				&& !reg_mod_ctrl[pcr_pkg::POS_AUX_MOD];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Chip-select action, optionally held until a reference rising edge
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cs_pending <= 1'b0;
			o_cs_apply <= 1'b0;
		end else if (i_clock_en) begin
			if (reg_pol_sync[pcr_pkg::POS_CS_SYNC]) begin
				o_cs_apply <= (cs_pending || i_cs_event) && ref_edge;
				if (ref_edge) begin
					cs_pending <= 1'b0;
				end else if (i_cs_event) begin
					cs_pending <= 1'b1;
				end
			end else begin
				o_cs_apply <= i_cs_event;
				cs_pending <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mask reset pulse on integer divider write
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mask_reset <= 1'b0;
		end else if (i_clock_en) begin
			o_mask_reset <= i_wr_strobe && (i_addr == pcr_pkg::ADDR_INT_DIVIDER)
				&& reg_mod_ctrl[pcr_pkg::POS_MASK_RST];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	pcr_lock_detect u_lock (
		.i_clock       (i_clock),
		.i_arst_n      (i_arst_n),
		.i_enable      (i_clock_en),
		.i_pfd_cycle   (i_pfd_cycle),
		.i_in_window   (i_in_window),
		.i_ref_edge    (ref_edge),
		.i_count_sel   (reg_lock_count_select[pcr_pkg::POS_COUNT_LO +: 2]),
		.i_loss_enable (reg_lock_count_select[pcr_pkg::POS_LOSS_EN]),
		.o_locked      (locked)
	);

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_locked <= 1'b0;
		end else if (i_clock_en) begin
			o_locked <= locked;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	a_write_readback: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		wr_ok && i_addr == pcr_pkg::ADDR_MOD_CTRL ##1 i_clock_en && i_rd_strobe
		&& !i_wr_strobe && i_addr == pcr_pkg::ADDR_MOD_CTRL
		|=> o_rdata == $past(i_wdata, 2))
		else $error("readback differs from write");
	a_mask_reset_gate: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		o_mask_reset |-> $past(reg_mod_ctrl[pcr_pkg::POS_MASK_RST]))
		else $error("mask reset while disabled");
	a_half_lsb_gate: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		o_half_lsb_active |-> $past(!reg_mod_ctrl[pcr_pkg::POS_AUX_MOD]))
		else $error("half lsb with aux modulator on");
	a_bleed_follows: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_clock_en |=> o_analog.bleed_current_enable
		== $past(reg_ld_bleed_vco[pcr_pkg::POS_BLEED_EN]))
		else $error("bleed enable not following register");
	a_cs_sync_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		o_cs_apply && $past(reg_pol_sync[pcr_pkg::POS_CS_SYNC]) |-> $past(ref_edge))
		else $error("chip select applied off reference edge");
	a_reset_zero: assert property (@(posedge i_clock)
		!i_arst_n |-> reg_mod_ctrl == 8'h00 && reg_lock_count_select == 8'h00)
		else $error("register not zero in reset");
	a_pd_follows: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_clock_en |=> o_analog.modulator_power_down
		== $past(reg_mod_ctrl[pcr_pkg::POS_MOD_PD]))
		else $error("modulator power-down not following");
	a_polarity_follows: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_clock_en |=> o_analog.bleed_polarity
		== $past(reg_pol_sync[pcr_pkg::POS_POLARITY]))
		else $error("polarity not following");
endmodule

// ---- bench/pcr_config_regs_test.sv ----
// Directed testbench for the synthesizer configuration bank
`timescale 1ns/1ps
module pcr_config_regs_test;
	logic                 i_clock;
	logic                 i_arst_n;
	logic                 i_clock_en;
	logic                 i_wr_strobe;
	logic                 i_rd_strobe;
	logic [7:0]           i_addr;
	logic [7:0]           i_wdata;
	logic                 i_cs_event;
	logic                 i_ref_in;
	logic                 i_pfd_cycle;
	logic                 i_in_window;
	logic [7:0]           o_rdata;
	logic                 o_rvalid;
	pcr_pkg::pcr_analog_t o_analog;
	logic                 o_locked;
	logic                 o_bleed_active;
	logic                 o_cs_apply;
	logic                 o_mask_reset;
	logic                 o_half_lsb_active;
	int                   num_errors;
	int                   n_tests;
	int                   n_cs;
	int                   n_mask;
	int                   base;
	logic                 ref_run;
	logic [1:0]           div;
	logic [7:0]           d;
	logic [7:0]           adr [4];
	logic [7:0]           pat [4];

	pcr_config_regs dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_clock_en(i_clock_en),
		.i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_cs_event(i_cs_event), .i_ref_in(i_ref_in),
		.i_pfd_cycle(i_pfd_cycle), .i_in_window(i_in_window), .o_rdata(o_rdata),
		.o_rvalid(o_rvalid), .o_analog(o_analog), .o_locked(o_locked),
		.o_bleed_active(o_bleed_active), .o_cs_apply(o_cs_apply),
		.o_mask_reset(o_mask_reset), .o_half_lsb_active(o_half_lsb_active));

	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	// Reference toggles every four clocks while running, else it stands
	always @(posedge i_clock) begin
		div <= div + 2'h1;
		if (ref_run && div == 2'h3) i_ref_in <= ~i_ref_in;
		if (o_cs_apply === 1'b1) n_cs++;
		if (o_mask_reset === 1'b1) n_mask++;
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clock);
		i_wr_strobe <= 1'b1;
		i_addr      <= a;
		i_wdata     <= v;
		@(posedge i_clock);
		i_wr_strobe <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_clock);
		i_rd_strobe <= 1'b1;
		i_addr      <= a;
		@(posedge i_clock);
		i_rd_strobe <= 1'b0;
		#1;
		chk("rvalid", 8'h01, o_rvalid);
		v = o_rdata;
	endtask

	task automatic pfd(input int n, input logic w);
		@(posedge i_clock);
		i_pfd_cycle <= 1'b1;
		i_in_window <= w;
		repeat (n) @(posedge i_clock);
		i_pfd_cycle <= 1'b0;
		repeat (3) @(posedge i_clock);
		#1;
	endtask

	task automatic settle();
		repeat (3) @(posedge i_clock);
		#1;
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#300000;
		num_errors++;
		test_done();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		{i_wr_strobe, i_rd_strobe, i_cs_event, i_ref_in, i_pfd_cycle, i_in_window} = '0;
		{num_errors, n_tests, n_cs, n_mask} = '0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_clock_en = 1'b1;
		ref_run = 1'b1;
		div = 2'h0;
		i_arst_n = 1'b0;
		adr = '{pcr_pkg::ADDR_LD_BLEED_VCO, pcr_pkg::ADDR_LOCK_COUNT_SELECT,
			pcr_pkg::ADDR_POL_SYNC, pcr_pkg::ADDR_MOD_CTRL};
		pat = '{8'he7, 8'hf9, 8'hd7, 8'hca};
		repeat (20) @(posedge i_clock);
		i_arst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(adr[i], d);
			chk("reset value", pcr_pkg::RESET_VALUE, d);
		end
		chk("locked at reset", 8'h00, o_locked);
		@(posedge i_clock);
		i_clock_en <= 1'b0;
		wr(pcr_pkg::ADDR_POL_SYNC, 8'hff);
		i_clock_en <= 1'b1;
		rd(pcr_pkg::ADDR_POL_SYNC, d);
		chk("frozen write", 8'h00, d);
		for (int i = 0; i < 4; i++) begin
			wr(adr[i], pat[i]);
			rd(adr[i], d);
			chk("readback", pat[i], d);
			wr(adr[i], 8'h00);
		end
		wr(8'h30, 8'h5a);
		rd(8'h30, d);
		chk("unmapped read", 8'h00, d);
		$display("test registers done");

		for (int k = 0; k < 4; k++) begin
			wr(pcr_pkg::ADDR_LD_BLEED_VCO, 8'h1c | 8'(k));
			settle();
			chk("bias select", 8'(k), o_analog.prescaler_bias_select);
			chk("bleed enable", 8'h01, o_analog.bleed_current_enable);
			chk("gated bleed", 8'h01, o_analog.gated_bleed_enable);
			chk("osc power down", 8'h01, o_analog.oscillator_power_down);
		end
		wr(pcr_pkg::ADDR_LD_BLEED_VCO, 8'h00);
		wr(pcr_pkg::ADDR_POL_SYNC, 8'h20);
		settle();
		chk("bleed enable off", 8'h00, o_analog.bleed_current_enable);
		chk("polarity", 8'h01, o_analog.bleed_polarity);
		wr(pcr_pkg::ADDR_MOD_CTRL, 8'h21);
		settle();
		chk("mod power down", 8'h01, o_analog.modulator_power_down);
		chk("half lsb", 8'h01, o_half_lsb_active);
		chk("half lsb raw", 8'h01, o_analog.half_lsb_add);
		base = n_mask;
		wr(pcr_pkg::ADDR_INT_DIVIDER, 8'h11);
		settle();
		chk("no mask reset", 8'(base), 8'(n_mask));
		wr(pcr_pkg::ADDR_MOD_CTRL, 8'h34);
		settle();
		chk("aux modulator", 8'h01, o_analog.aux_modulator_enable);
		chk("half lsb aux on", 8'h00, o_half_lsb_active);
		chk("mod powered", 8'h00, o_analog.modulator_power_down);
		wr(pcr_pkg::ADDR_INT_DIVIDER, 8'h12);
		settle();
		chk("mask reset", 8'(base + 1), 8'(n_mask));
		$display("test analog done");

		wr(pcr_pkg::ADDR_POL_SYNC, 8'h00);
		base = n_cs;
		pfd(1, 1'b0);
		@(posedge i_clock);
		i_cs_event <= 1'b1;
		@(posedge i_clock);
		i_cs_event <= 1'b0;
		settle();
		chk("cs direct", 8'(base + 1), 8'(n_cs));
		wr(pcr_pkg::ADDR_POL_SYNC, 8'h08);
		ref_run <= 1'b0;
		// Let a last reference edge drain through the synchroniser
		repeat (6) @(posedge i_clock);
		@(posedge i_clock);
		i_cs_event <= 1'b1;
		@(posedge i_clock);
		i_cs_event <= 1'b0;
		repeat (10) @(posedge i_clock);
		#1;
		chk("cs held", 8'(base + 1), 8'(n_cs));
		ref_run <= 1'b1;
		repeat (20) @(posedge i_clock);
		#1;
		chk("cs on ref", 8'(base + 2), 8'(n_cs));
		$display("test sync done");

		for (int k = 0; k < 4; k++) begin
			wr(pcr_pkg::ADDR_LOCK_COUNT_SELECT, 8'(k << 1));
			pfd(1, 1'b0);
			pfd((1024 << k) - 4, 1'b1);
			chk("not yet locked", 8'h00, o_locked);
			pfd(8, 1'b1);
			chk("locked", 8'h01, o_locked);
		end
		wr(pcr_pkg::ADDR_LOCK_COUNT_SELECT, 8'h01);
		wr(pcr_pkg::ADDR_LD_BLEED_VCO, 8'h18);
		pfd(1, 1'b0);
		chk("window miss", 8'h00, o_locked);
		settle();
		chk("gated bleed off", 8'h00, o_bleed_active);
		pfd(1030, 1'b1);
		chk("relocked", 8'h01, o_locked);
		chk("gated bleed on", 8'h01, o_bleed_active);
		ref_run <= 1'b0;
		repeat (48) @(posedge i_clock);
		#1;
		chk("lock before stall", 8'h01, o_locked);
		repeat (30) @(posedge i_clock);
		#1;
		chk("lock lost", 8'h00, o_locked);
		ref_run <= 1'b1;
		wr(pcr_pkg::ADDR_LOCK_COUNT_SELECT, 8'h00);
		pfd(1030, 1'b1);
		ref_run <= 1'b0;
		repeat (150) @(posedge i_clock);
		#1;
		chk("no loss monitor", 8'h01, o_locked);
		ref_run <= 1'b1;
		$display("test lock done");
		test_done();
	end
endmodule
